/* adsf_defs.svh */
// Constants for the attendant select and dial pulse filter block.
// Assumes a 200 MHz clock; included by bare name.
`ifndef ADSF_DEFS_SVH
`define ADSF_DEFS_SVH
// ==========================================================
// Store word fields
`define ADSF_GROUP_HI 6
`define ADSF_GROUP_LO 5
`define ADSF_MEMBER_HI 13
`define ADSF_MEMBER_LO 12
// ==========================================================
// Sizes
`define ADSF_ATTENDANTS 12
`define ADSF_PER_GROUP 3
`define ADSF_TRUNKS 6
`define ADSF_TRUNKS_PER_BUS 6
// ==========================================================
// Timing
`define ADSF_CLK_PS 5000
`define ADSF_SWITCH_NS 800
`define ADSF_SWITCH_CYC ((`ADSF_SWITCH_NS * 1000) / `ADSF_CLK_PS)
`define ADSF_HIT_MS 75
`define ADSF_ONHOOK_MS 300
`define ADSF_FLASH_MS 100
`define ADSF_BURST_MS 50
// Scaled down first so the product stays inside 32-bit integer arithmetic
`define ADSF_MS_CYC(ms) (((ms) * 1000000) / (`ADSF_CLK_PS / 1000))
`define ADSF_FLASH_CYC `ADSF_MS_CYC(`ADSF_FLASH_MS)
`define ADSF_BURST_CYC `ADSF_MS_CYC(`ADSF_BURST_MS)
`define ADSF_TIMER_W 25
`endif

/* adsf_pkg.sv */
// Types for the attendant select and dial pulse filter block.
// Assumes adsf_defs.svh is on the include path.
`include "adsf_defs.svh"
package adsf_pkg;
  typedef logic [`ADSF_ATTENDANTS-1:0] adsf_att_t;
  typedef logic [`ADSF_TRUNKS-1:0] adsf_trunk_t;
  typedef logic [`ADSF_TIMER_W-1:0] adsf_timer_t;
  typedef enum logic [2:0] {
    VERDICT_NONE,
    VERDICT_ADVANCE,
    VERDICT_HOLD,
    VERDICT_MSG_DIRECT,
    VERDICT_MSG_REINT
  } adsf_verdict_t;
endpackage

/* adsf_core.sv */
// Attendant selection, digit trunk supervision and scanner dial pulse filter for one time division control.
// Assumes all inputs come from store, pretranslator and scanner logic on clk.
//
// How it works
// RULE1: Decode store word bits 6,5,13,12.
// RULE2: Bits 6,5 pick group; 13,12 member.
// RULE3: Attendant switch closes on select plus strobe.
// RULE4: Relay held while one select per cycle.
// RULE5: Twelve consoles, one line per control.
// RULE6: Trunks map to buses in sixes.
// RULE7: Six trunk switches follow scan bus state.
// RULE8: Off-hook trunk pulses inhibit in its slot.
// RULE9: Short on-hook hits keep inhibit running.
// RULE10: Long on-hook times out the filter.
// RULE11: One fixed burst per on-hook transition.
// RULE12: Compare scan counter with calling address.
// RULE13: Off-hook change: no advance, no message.
// RULE14: On-hook change: force advance, no message.
// RULE15: Flash start treated as dial pulse.
// RULE16: Flash timeout sends direct on-hook message.
// RULE17: Return off-hook resumes inhibit, reinterrogates.
// RULE18: Abandon reports like flash timeout.
// RULE19: Enabled switch stays closed 800 ns.
// RULE20: Inhibit in slot masks as off-hook.
`timescale 1ns/1ps
`include "adsf_defs.svh"
module adsf_core
  import adsf_pkg::*;
#(
  parameter int unsigned FLASH_CYC = `ADSF_FLASH_CYC,
  parameter int unsigned BURST_CYC = `ADSF_BURST_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] tdcNumber,
  input wire logic [31:0] storeWord,
  input wire logic storeWordValid,
  input wire logic storeCycleStart,
  input wire logic specialGroupStrobe,
  input wire adsf_trunk_t digitTrunkEnable,
  input wire logic scanBusState,
  input wire logic [9:0] scanCountLow,
  input wire logic [9:0] callingAddress,
  input wire logic changeDetected,
  input wire logic scanPointOffHook,
  input wire logic lastLookOffHook,
  output adsf_att_t attendantSelect,
  output adsf_att_t attendantSwitchClosed,
  output adsf_att_t attendantRelay,
  output adsf_trunk_t trunkSwitchClosed,
  output logic trunkSwitchLevel,
  output logic [4:0] trunkFirstNumber,
  output logic digitTrunkScanInhibit,
  output adsf_trunk_t toneBurst,
  output logic forceAdvance,
  output logic sendMessage,
  output logic skipReinterrogation
);
  localparam adsf_timer_t FLASH_CNT = adsf_timer_t'(FLASH_CYC);
  localparam adsf_timer_t BURST_CNT = adsf_timer_t'(BURST_CYC);
  localparam logic [7:0] SWITCH_CNT = 8'(`ADSF_SWITCH_CYC);

  // ==========================================================
  // Functions
  function automatic adsf_att_t att_decode(input logic [1:0] grp, input logic [1:0] member);
    logic [3:0] idx;
    idx = 4'(grp * `ADSF_PER_GROUP) + 4'(member) - 4'h1;
    att_decode = (member == 2'h0) ? '0 : adsf_att_t'(1) << idx;
  endfunction

  function automatic logic [1:0] bus_of_trunk(input logic [4:0] number);
    bus_of_trunk = 2'((number - 5'h01) / 5'(`ADSF_TRUNKS_PER_BUS));
  endfunction

  // ==========================================================
  // Attendant selection
  wire logic [1:0] attGroup = storeWord[`ADSF_GROUP_HI:`ADSF_GROUP_LO]; // RULE1
  wire logic [1:0] attMember = storeWord[`ADSF_MEMBER_HI:`ADSF_MEMBER_LO]; // RULE1
  wire adsf_att_t attDecoded = storeWordValid ? att_decode(attGroup, attMember) : '0; // RULE2 RULE5

  adsf_att_t attendantSelect_q;
  adsf_att_t relay_q;
  adsf_att_t relaySeen_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      attendantSelect_q <= '0;
    end else begin
      attendantSelect_q <= attDecoded;
    end
  end

  // Set wins over the store cycle roll so a pulse on the boundary is kept
  wire adsf_att_t relaySeenD = storeCycleStart ? attendantSelect_q : (relaySeen_q | attendantSelect_q); // RULE4
  wire adsf_att_t relayD = storeCycleStart ? (relaySeen_q | attendantSelect_q) : (relay_q | attendantSelect_q); // RULE4
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relaySeen_q <= '0;
      relay_q <= '0;
    end else begin
      relaySeen_q <= relaySeenD;
      relay_q <= relayD;
    end
  end

  // ==========================================================
  // Switch closure timing, shared by all switches of this control
  logic [7:0] swTimer_q;
  adsf_att_t attSwMask_q;
  adsf_trunk_t trunkSwMask_q;
  logic trunkLevel_q;
  wire logic swLoad = specialGroupStrobe && ((|attendantSelect_q) || (|digitTrunkEnable)); // RULE3 RULE7
  wire logic swActive = (swTimer_q != 8'h00);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swTimer_q <= 8'h00;
      attSwMask_q <= '0;
      trunkSwMask_q <= '0;
      trunkLevel_q <= 1'b0;
    end else if (swLoad) begin
      swTimer_q <= SWITCH_CNT; // RULE19
      attSwMask_q <= attendantSelect_q; // RULE3
      trunkSwMask_q <= digitTrunkEnable; // RULE7
      trunkLevel_q <= scanBusState; // RULE7
    end else if (swActive) begin
      swTimer_q <= swTimer_q - 8'h01; // RULE19
    end
  end

  // ==========================================================
  // Digit trunk supervision
  logic [4:0] trunkFirst_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trunkFirst_q <= 5'h01;
    end else begin
      trunkFirst_q <= 5'(tdcNumber * `ADSF_TRUNKS_PER_BUS) + 5'h01; // RULE6
    end
  end

  adsf_trunk_t assigned_q;
  adsf_trunk_t assignSeen_q;
  adsf_trunk_t partyOffHook_q;
  adsf_trunk_t timedOut;
  adsf_trunk_t burstStart;
  adsf_trunk_t burstOn;
  adsf_timer_t onHookCnt_q [`ADSF_TRUNKS];
  adsf_timer_t burstCnt_q [`ADSF_TRUNKS];

  wire adsf_trunk_t assignSeenD = storeCycleStart ? digitTrunkEnable : (assignSeen_q | digitTrunkEnable);
  wire adsf_trunk_t assignedD = storeCycleStart ? (assignSeen_q | digitTrunkEnable) : (assigned_q | digitTrunkEnable);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      assignSeen_q <= '0;
      assigned_q <= '0;
    end else begin
      assignSeen_q <= assignSeenD;
      assigned_q <= assignedD;
    end
  end

  for (genvar i = 0; i < `ADSF_TRUNKS; i++) begin : g_trunk
    // A newly assigned party counts as off-hook
    wire logic sampleNow = digitTrunkEnable[i];
    assign timedOut[i] = (onHookCnt_q[i] >= FLASH_CNT); // RULE10 RULE16
    assign burstStart[i] = sampleNow && assigned_q[i] && partyOffHook_q[i] && !scanBusState; // RULE11
    assign burstOn[i] = (burstCnt_q[i] != '0);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        partyOffHook_q[i] <= 1'b1;
        onHookCnt_q[i] <= '0;
        burstCnt_q[i] <= '0;
      end else begin
        if (!assigned_q[i] && !sampleNow) begin
          partyOffHook_q[i] <= 1'b1;
        end else if (sampleNow) begin
          partyOffHook_q[i] <= scanBusState;
        end
        // Hits shorter than the timeout never reach it, so inhibit keeps going
        if (partyOffHook_q[i] || !assigned_q[i]) begin
          onHookCnt_q[i] <= '0; // RULE9 RULE17
        end else if (!timedOut[i]) begin
          onHookCnt_q[i] <= onHookCnt_q[i] + 1'b1; // RULE9 RULE15
        end
        // Burst length is fixed and ignores how long the pulse lasts
        if (burstStart[i]) begin
          burstCnt_q[i] <= BURST_CNT; // RULE11
        end else if (burstOn[i]) begin
          burstCnt_q[i] <= burstCnt_q[i] - 1'b1; // RULE11
        end
      end
    end
  end

  wire logic inhibitNow = |(digitTrunkEnable & ~timedOut); // RULE8 RULE15
  logic inhibit_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inhibit_q <= 1'b0;
    end else begin
      inhibit_q <= inhibitNow; // RULE8
    end
  end

  // ==========================================================
  // Scanner dial pulse filter
  wire logic matchNow = storeWordValid && (|digitTrunkEnable) && (scanCountLow == callingAddress); // RULE12
  logic callerMatch_q;
  logic inhibitSeen_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      callerMatch_q <= 1'b0;
      inhibitSeen_q <= 1'b0;
    end else begin
      callerMatch_q <= matchNow || (callerMatch_q && !storeCycleStart); // RULE12
      inhibitSeen_q <= (matchNow && inhibitNow) || (inhibitSeen_q && !storeCycleStart); // RULE20
    end
  end

  // Inhibit seen in the party's slot masks the scan point as off-hook
  adsf_verdict_t verdict;
  always_comb begin
    verdict = VERDICT_NONE;
    if (changeDetected) begin
      if (!callerMatch_q) begin
        verdict = VERDICT_MSG_REINT;
      end else if (!inhibitSeen_q) begin
        verdict = VERDICT_MSG_DIRECT; // RULE16 RULE18
      end else if (!scanPointOffHook) begin
        verdict = VERDICT_ADVANCE; // RULE14 RULE15
      end else if (!lastLookOffHook) begin
        verdict = VERDICT_MSG_REINT; // RULE17
      end else begin
        verdict = VERDICT_HOLD; // RULE13 RULE20
      end
    end
  end

  logic advance_q;
  logic message_q;
  logic direct_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      advance_q <= 1'b0;
      message_q <= 1'b0;
      direct_q <= 1'b0;
    end else begin
      case (verdict)
        VERDICT_ADVANCE: begin
          advance_q <= 1'b1;
          message_q <= 1'b0;
          direct_q <= 1'b0;
        end
        VERDICT_MSG_DIRECT: begin
          advance_q <= 1'b0;
          message_q <= 1'b1;
          direct_q <= 1'b1;
        end
        VERDICT_MSG_REINT: begin
          advance_q <= 1'b0;
          message_q <= 1'b1;
          direct_q <= 1'b0;
        end
        default: begin
          advance_q <= 1'b0;
          message_q <= 1'b0;
          direct_q <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign attendantSelect = attendantSelect_q;
  assign attendantSwitchClosed = swActive ? attSwMask_q : '0;
  assign attendantRelay = relay_q;
  assign trunkSwitchClosed = swActive ? trunkSwMask_q : '0;
  assign trunkSwitchLevel = trunkLevel_q;
  assign trunkFirstNumber = trunkFirst_q;
  assign digitTrunkScanInhibit = inhibit_q;
  assign toneBurst = burstOn;
  assign forceAdvance = advance_q;
  assign sendMessage = message_q;
  assign skipReinterrogation = direct_q;

  // ==========================================================
  // Assertions
  logic [8:0] closedLen_q;
  adsf_att_t strobeSel_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      closedLen_q <= 9'h000;
      strobeSel_q <= '0;
    end else begin
      closedLen_q <= (swActive && !swLoad) ? closedLen_q + 9'h001 : 9'h000;
      strobeSel_q <= (specialGroupStrobe && attendantSelect != '0) ? attendantSelect : strobeSel_q;
    end
  end

  property p_attDecode;
    @(posedge clk) disable iff (rst)
      (storeWordValid && storeWord[13:12] != 2'h0) |=> ($onehot(attendantSelect)
        && attendantSelect == att_decode($past(storeWord[6:5]), $past(storeWord[13:12])));
  endproperty
  a_attDecode: assert property (p_attDecode) else $error("attendant decode wrong"); // RULE1 RULE2

  property p_attNone;
    @(posedge clk) disable iff (rst)
      (storeWord[13:12] == 2'h0) |=> (attendantSelect == '0);
  endproperty
  a_attNone: assert property (p_attNone) else $error("attendant selected with zero member"); // RULE2

  property p_switchClose;
    @(posedge clk) disable iff (rst)
      (specialGroupStrobe && attendantSelect != '0) |=> (attendantSwitchClosed == strobeSel_q)[*8];
  endproperty
  a_switchClose: assert property (p_switchClose) else $error("attendant switch not closed"); // RULE3

  property p_switchLen;
    @(posedge clk) disable iff (rst)
      closedLen_q <= 9'(`ADSF_SWITCH_CYC);
  endproperty
  a_switchLen: assert property (p_switchLen) else $error("switch closed too long"); // RULE19

  property p_relayHold;
    @(posedge clk) disable iff (rst)
      (attendantSelect != '0) |=> ((attendantRelay & $past(attendantSelect)) == $past(attendantSelect));
  endproperty
  a_relayHold: assert property (p_relayHold) else $error("relay not held"); // RULE4

  property p_relayDrop;
    @(posedge clk) disable iff (rst)
      (storeCycleStart && relaySeen_q == '0 && attendantSelect == '0) |=> (attendantRelay == '0);
  endproperty
  a_relayDrop: assert property (p_relayDrop) else $error("relay held without pulses"); // RULE4

  property p_bus;
    @(posedge clk) disable iff (rst)
      $stable(tdcNumber) |=> (bus_of_trunk(trunkFirstNumber) == $past(tdcNumber));
  endproperty
  a_bus: assert property (p_bus) else $error("trunk bus mapping wrong"); // RULE6

  property p_inhibitSlot;
    @(posedge clk) disable iff (rst)
      digitTrunkScanInhibit |-> $past(|digitTrunkEnable);
  endproperty
  a_inhibitSlot: assert property (p_inhibitSlot) else $error("inhibit outside trunk slot"); // RULE8

  property p_timeout;
    @(posedge clk) disable iff (rst)
      (digitTrunkEnable == 6'h01 && timedOut[0]) |=> !digitTrunkScanInhibit;
  endproperty
  a_timeout: assert property (p_timeout) else $error("inhibit after timeout"); // RULE10 RULE16

  property p_burst;
    @(posedge clk) disable iff (rst)
      burstStart[0] |=> toneBurst[0] ##1 toneBurst[0];
  endproperty
  a_burst: assert property (p_burst) else $error("burst not started"); // RULE11

  property p_advance;
    @(posedge clk) disable iff (rst)
      (changeDetected && callerMatch_q && inhibitSeen_q && !scanPointOffHook) |=> (forceAdvance && !sendMessage);
  endproperty
  a_advance: assert property (p_advance) else $error("dial pulse not filtered"); // RULE14

  property p_hold;
    @(posedge clk) disable iff (rst)
      (changeDetected && callerMatch_q && inhibitSeen_q && scanPointOffHook && lastLookOffHook)
        |=> (!forceAdvance && !sendMessage);
  endproperty
  a_hold: assert property (p_hold) else $error("off-hook change not held"); // RULE13 RULE20

  property p_direct;
    @(posedge clk) disable iff (rst)
      (changeDetected && callerMatch_q && !inhibitSeen_q) |=> (sendMessage && skipReinterrogation);
  endproperty
  a_direct: assert property (p_direct) else $error("flash message not direct"); // RULE16 RULE18

  property p_reint;
    @(posedge clk) disable iff (rst)
      (changeDetected && callerMatch_q && inhibitSeen_q && scanPointOffHook && !lastLookOffHook)
        |=> (sendMessage && !skipReinterrogation);
  endproperty
  a_reint: assert property (p_reint) else $error("return off-hook not reinterrogated"); // RULE17

  c_flash: cover property (@(posedge clk) disable iff (rst) sendMessage && skipReinterrogation);
  c_advance: cover property (@(posedge clk) disable iff (rst) forceAdvance);
  c_relay: cover property (@(posedge clk) disable iff (rst) attendantRelay != '0 ##1 attendantRelay == '0);
  c_burst: cover property (@(posedge clk) disable iff (rst) $rose(toneBurst[0]));

endmodule // adsf_core

/* adsf_scan_model.sv */
// Scanner and control side model: scan bus, scan counter, change pulses.
// Assumes the bench drives its requests by non-blocking assignment on clk.
`timescale 1ns/1ps
module adsf_scan_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic partyOffHook,
  input wire logic [9:0] scanAddress,
  input wire logic changeReq,
  input wire logic lastLookReq,
  output logic scanBusState,
  output logic [9:0] scanCountLow,
  output logic changeDetected,
  output logic scanPointOffHook,
  output logic lastLookOffHook
);
  // ==========================================================
  // Scan side
  // State bits toggle outside change pulses, so a stale value is never trusted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scanBusState <= 1'b1;
      scanCountLow <= 10'h000;
      changeDetected <= 1'b0;
      scanPointOffHook <= 1'b0;
      lastLookOffHook <= 1'b0;
    end else begin
      scanBusState <= partyOffHook;
      scanCountLow <= scanAddress;
      changeDetected <= changeReq;
      scanPointOffHook <= changeReq ? partyOffHook : ~scanPointOffHook;
      lastLookOffHook <= changeReq ? lastLookReq : ~lastLookOffHook;
    end
  end
endmodule // adsf_scan_model

/* adsf_core_bench.sv */
// Self-checking bench for the attendant select and dial pulse filter core.
// Assumes adsf_pkg is compiled first; short timeouts via parameters.
`timescale 1ns/1ps
module adsf_core_bench
  import adsf_pkg::*;
;
  // ==========================================================
  // Signals
  localparam int FL = 200;
  localparam int BU = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] tdcNumber = 2'h0;
  logic [31:0] storeWord = 32'h0;
  logic storeWordValid = 1'b0, storeCycleStart = 1'b0, specialGroupStrobe = 1'b0;
  adsf_trunk_t digitTrunkEnable = 6'h00;
  logic [9:0] callingAddress = 10'h000, scanAddress = 10'h000, callAddr;
  logic partyOffHook = 1'b1, changeReq = 1'b0, lastLookReq = 1'b0;
  logic scanBusState, changeDetected, scanPointOffHook, lastLookOffHook;
  logic [9:0] scanCountLow;
  adsf_att_t attendantSelect, attendantSwitchClosed, attendantRelay;
  adsf_trunk_t trunkSwitchClosed, toneBurst;
  logic trunkSwitchLevel, digitTrunkScanInhibit, forceAdvance, sendMessage, skipReinterrogation;
  logic [4:0] trunkFirstNumber;
  logic [31:0] seed = 32'h000117fc;
  int n_fail = 0, n_tests = 0, cycN = 0, onCnt = 0, burstT = -1000;
  bit prevOff = 1'b1, expInh = 1'b1;
  always #2.5 clk = ~clk;
  always @(posedge clk) cycN <= cycN + 1;

  adsf_core #(.FLASH_CYC(FL), .BURST_CYC(BU)) adsf_core_inst (.clk(clk), .rst(rst), .tdcNumber(tdcNumber),
    .storeWord(storeWord), .storeWordValid(storeWordValid), .storeCycleStart(storeCycleStart),
    .specialGroupStrobe(specialGroupStrobe), .digitTrunkEnable(digitTrunkEnable), .scanBusState(scanBusState),
    .scanCountLow(scanCountLow), .callingAddress(callingAddress), .changeDetected(changeDetected),
    .scanPointOffHook(scanPointOffHook), .lastLookOffHook(lastLookOffHook), .attendantSelect(attendantSelect),
    .attendantSwitchClosed(attendantSwitchClosed), .attendantRelay(attendantRelay),
    .trunkSwitchClosed(trunkSwitchClosed), .trunkSwitchLevel(trunkSwitchLevel),
    .trunkFirstNumber(trunkFirstNumber), .digitTrunkScanInhibit(digitTrunkScanInhibit), .toneBurst(toneBurst),
    .forceAdvance(forceAdvance), .sendMessage(sendMessage), .skipReinterrogation(skipReinterrogation));
  adsf_scan_model adsf_scan_model_inst (.clk(clk), .rst(rst), .partyOffHook(partyOffHook),
    .scanAddress(scanAddress), .changeReq(changeReq), .lastLookReq(lastLookReq), .scanBusState(scanBusState),
    .scanCountLow(scanCountLow), .changeDetected(changeDetected), .scanPointOffHook(scanPointOffHook),
    .lastLookOffHook(lastLookOffHook));

  // ==========================================================
  // Model and checks
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [11:0] expSel(input logic [31:0] w);
    int g;
    int m;
    g = w[6:5];
    m = w[13:12];
    return (m == 0) ? 12'h000 : 12'h001 << (g * 3 + m - 1);
  endfunction
  // Verdict bits are force advance, send, skip reinterrogation
  function automatic logic [2:0] expVerd(input bit m, input bit inh, input bit off, input bit ll);
    if (!m) return 3'h2;
    if (!inh) return 3'h3;
    if (!off) return 3'h4;
    if (!ll) return 3'h2;
    return 3'h0;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chkVerd(input logic [2:0] e);
    chk("verdict", 32'(e), {29'h0, forceAdvance, sendMessage, skipReinterrogation});
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One store cycle of eight clocks: attendant word in the second
  task automatic rc(input bit sel, input logic [31:0] w);
    @(posedge clk);
    storeCycleStart <= 1'b1;
    @(posedge clk);
    storeCycleStart <= 1'b0;
    storeWordValid <= sel;
    storeWord <= w;
    @(posedge clk);
    storeWordValid <= 1'b0;
    #1;
    chk("select", sel ? 32'(expSel(w)) : 32'h0, 32'(attendantSelect));
    repeat (5) @(posedge clk);
  endtask
  // One store cycle with trunk 0's slot; inhibit near the timeout edge is not judged
  task automatic sc(input bit party, input bit chg, input bit ll, input bit stb, input bit ci);
    bit m;
    @(posedge clk);
    storeCycleStart <= 1'b1;
    partyOffHook <= party;
    @(posedge clk);
    storeCycleStart <= 1'b0;
    storeWordValid <= 1'b1;
    storeWord <= rnd() & 32'hffffcfff;
    digitTrunkEnable <= 6'h01;
    callingAddress <= callAddr;
    specialGroupStrobe <= stb;
    @(posedge clk);
    storeWordValid <= 1'b0;
    digitTrunkEnable <= 6'h00;
    specialGroupStrobe <= 1'b0;
    changeReq <= chg;
    lastLookReq <= ll;
    #1;
    onCnt = (party || prevOff) ? 0 : onCnt + 8;
    if (!party && prevOff) burstT = cycN;
    prevOff = party;
    expInh = onCnt < FL;
    if (ci && (onCnt < FL - 16 || onCnt > FL + 16)) chk("inhibit", 32'(expInh), 32'(digitTrunkScanInhibit));
    chk("tone", 32'((cycN - burstT) < BU), 32'(toneBurst));
    if (stb) chk("trunk switch", {25'h0, party, 6'h01}, {25'h0, trunkSwitchLevel, trunkSwitchClosed});
    @(posedge clk);
    changeReq <= 1'b0;
    @(posedge clk);
    #1;
    m = callAddr == scanAddress;
    chkVerd(chg ? expVerd(m, expInh, party, ll) : 3'h0);
    repeat (3) @(posedge clk);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    logic [31:0] w;
    repeat (3) @(posedge clk);
    #1;
    chk("reset", 32'h00040000, {trunkFirstNumber, attendantSelect, toneBurst});
    repeat (13) @(posedge clk);
    rst <= 1'b0;
    for (int t = 0; t < 4; t++) begin
      @(posedge clk);
      tdcNumber <= 2'(t);
      repeat (2) @(posedge clk);
      #1;
      chk("first trunk", t * 6 + 1, 32'(trunkFirstNumber));
    end
    for (int i = 0; i < 16; i++) rc(1'b1, (rnd() & 32'hffffcf9f) | (32'(i[3:2]) << 5) | (32'(i[1:0]) << 12));
    rc(1'b0, 32'h0);
    rc(1'b0, 32'h0);
    chk("relay idle", 32'h0, 32'(attendantRelay));
    w = (rnd() & 32'hffffcf9f) | 32'h00002040;
    repeat (3) begin
      rc(1'b1, w);
      chk("relay held", 32'(expSel(w)), 32'(attendantRelay));
    end
    rc(1'b0, 32'h0);
    rc(1'b0, 32'h0);
    chk("relay drop", 32'h0, 32'(attendantRelay));
    @(posedge clk);
    storeWordValid <= 1'b1;
    storeWord <= w;
    @(posedge clk);
    storeWordValid <= 1'b0;
    specialGroupStrobe <= 1'b1;
    @(posedge clk);
    specialGroupStrobe <= 1'b0;
    #1;
    chk("att switch", 32'(expSel(w)), 32'(attendantSwitchClosed));
    repeat (159) @(posedge clk);
    #1;
    chk("att switch hold", 32'(expSel(w)), 32'(attendantSwitchClosed));
    @(posedge clk);
    #1;
    chk("att switch open", 32'h0, 32'(attendantSwitchClosed));
    @(posedge clk);
    tdcNumber <= 2'(rnd());
    callAddr = 10'(rnd());
    scanAddress <= callAddr;
    sc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    sc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    sc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    sc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    sc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    repeat (3) sc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    for (int k = 0; k < 40; k++) sc(1'b0, k == 35, 1'b1, 1'b0, 1'b1);
    sc(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    sc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    scanAddress <= callAddr ^ 10'h001;
    sc(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    finish_test();
  end

  // Run needs under a thousand clocks
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule // adsf_core_bench
